// ### common/sfpfe_pkg.sv
// constants and types shared by the serial flash pin-mode front end
//
// Operation
// - With quad_lane_enable set, the shared pause pin stops pausing and serves as data_lane_3.
// - On dedicated-reset parts the shared pin is the pause input whenever quad_lane_enable is 0.
// - A low pause input with chip select low freezes the transfer without losing received bits.
// - While paused and selected, the serial output pin is left floating.
// - When the pause input rises again the transfer continues where it stopped.
// - While hardware reset is low the device is in reset and every output floats.
// - While hardware reset is high the device works normally and takes serial traffic.
// - On shared-pin parts pin_function_select 0 picks the pause input and 1 picks hardware reset.
// - In dual-lane mode the input and output pins become two-way data_lane_0 and data_lane_1.
// - In four-lane modes input, output, write-protect and pause pins become data lanes 0 to 3.
// - Only clock modes 0 (0,0) and 3 (1,1) are supported.
// - Lanes are sampled on the rising serial-clock edge and driven from the falling edge.
// - quad_lane_enable is status bit 6, 0 by default disabling four-lane use, 1 enabling it.
// - With chip select high the device floats its outputs, takes no data, and needs a fall first.
package sfpfe_pkg;

	// lane width of a transfer phase, set by the instruction decoder
	typedef enum logic [1:0] {
		SFPFE_LANES_ONE,
		SFPFE_LANES_TWO,
		SFPFE_LANES_FOUR
	} sfpfe_lanes_type;

	localparam int SFPFE_BYTE_W = 8;
	localparam int SFPFE_QE_BIT = 6; // position of quad_lane_enable in the status byte
	localparam logic SFPFE_QE_RESET = 1'h0; // four-lane use off by default
	localparam logic SFPFE_PFS_RESET = 1'h0; // pause function by default
	localparam logic [2:0] SFPFE_CNT_RESET = 3'h0;
	localparam logic [7:0] SFPFE_BYTE_RESET = 8'h00;
	localparam int SFPFE_SYNC_STAGES = 2;

endpackage : sfpfe_pkg

// ### logic/sfpfe_front_end.sv
// pin-mode front end of a serial flash: lane roles, pause, hardware reset, byte transfer
`timescale 1ns/10ps

module sfpfe_front_end #(
	parameter bit DEDICATED_RESET = 1'b0
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	// serial link, clocked by the master
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic reset_pin_n_i,
	input wire logic data_lane_0_i,
	output logic data_lane_0_o,
	output logic data_lane_0_oe_o,
	input wire logic data_lane_1_i,
	output logic data_lane_1_o,
	output logic data_lane_1_oe_o,
	input wire logic data_lane_2_i,
	output logic data_lane_2_o,
	output logic data_lane_2_oe_o,
	input wire logic data_lane_3_i,
	output logic data_lane_3_o,
	output logic data_lane_3_oe_o,
	// core side, on clk_i
	input wire logic quad_lane_enable_i,
	input wire logic pin_function_select_i,
	input wire logic [1:0] lane_mode_i,
	input wire logic out_dir_i,
	input wire logic [7:0] tx_data_i,
	input wire logic tx_valid_i,
	output logic tx_ready_o,
	output logic [7:0] rx_data_o,
	output logic rx_valid_o,
	output logic selected_o,
	output logic hold_active_o,
	output logic hw_reset_active_o,
	output logic write_protect_n_o
);

	// core-domain configuration registers
	logic quad_lane_enable;
	logic pin_function_select;
	logic [1:0] lane_mode;
	logic out_dir;
	logic next_quad_lane_enable;
	logic next_pin_function_select;
	logic [1:0] next_lane_mode;
	logic next_out_dir;

	// pin role decode, combinational so pads react at once
	logic pause_pin_role;
	logic reset_pin_role;
	logic hold_now;
	logic reset_now;
	logic armed;
	logic frame_rst_n;

	always_comb begin
		// shared pin is lane 3 in four-lane use, else pause or reset
		pause_pin_role = !quad_lane_enable && (DEDICATED_RESET || !pin_function_select);
		reset_pin_role = !quad_lane_enable && !DEDICATED_RESET && pin_function_select;
		hold_now = pause_pin_role && !data_lane_3_i && !cs_n_i;
		reset_now = DEDICATED_RESET ? !reset_pin_n_i : (reset_pin_role && !data_lane_3_i);
		// link logic runs only in a selected, armed frame out of reset
		frame_rst_n = !cs_n_i && !reset_now && armed && nrst_i;
	end

	// link domain: shifting on sck; counter and shift registers cleared by the frame's own signals, byte and ack toggles by nrst_i
	logic [2:0] bit_cnt;
	logic [7:0] rx_sr;
	logic [7:0] rx_byte;
	logic rx_tog;
	logic [7:0] tx_sr;
	logic tx_ack;
	logic [2:0] next_bit_cnt;
	logic [7:0] next_rx_sr;
	logic [7:0] next_rx_byte;
	logic next_rx_tog;
	logic [7:0] next_tx_sr;
	logic next_tx_ack;
	logic [7:0] tx_hold;
	logic tx_req;
	logic [2:0] step;
	logic [3:0] cnt_sum;
	logic [7:0] rx_shift;

	always_comb begin
		case (sfpfe_pkg::sfpfe_lanes_type'(lane_mode))
			sfpfe_pkg::SFPFE_LANES_ONE: begin
				step = 3'h1;
				rx_shift = {rx_sr[6:0], data_lane_0_i};
			end
			sfpfe_pkg::SFPFE_LANES_TWO: begin
				step = 3'h2;
				rx_shift = {rx_sr[5:0], data_lane_1_i, data_lane_0_i};
			end
			sfpfe_pkg::SFPFE_LANES_FOUR: begin
				step = 3'h4;
				rx_shift = {rx_sr[3:0], data_lane_3_i, data_lane_2_i,
					data_lane_1_i, data_lane_0_i};
			end
			default: begin
				step = 3'h1;
				rx_shift = {rx_sr[6:0], data_lane_0_i};
			end
		endcase
	end

	// rising edge: sample lanes, a held frame keeps its partial byte
	always_comb begin
		cnt_sum = {1'b0, bit_cnt} + {1'b0, step};
		next_bit_cnt = bit_cnt;
		next_rx_sr = rx_sr;
		next_rx_byte = rx_byte;
		next_rx_tog = rx_tog;
		if (!hold_now) begin
			next_bit_cnt = cnt_sum[2:0];
			next_rx_sr = rx_shift;
			if (cnt_sum[3]) begin
				next_rx_byte = rx_shift;
				next_rx_tog = !rx_tog;
			end
		end
	end

	always_ff @(posedge sck_i or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt <= sfpfe_pkg::SFPFE_CNT_RESET;
			rx_sr <= sfpfe_pkg::SFPFE_BYTE_RESET;
		end else begin
			bit_cnt <= next_bit_cnt;
			rx_sr <= next_rx_sr;
		end
	end

	// byte and toggle live across frames so the core never misses a byte
	always_ff @(posedge sck_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rx_byte <= sfpfe_pkg::SFPFE_BYTE_RESET;
			rx_tog <= 1'b0;
		end else begin
			rx_byte <= next_rx_byte;
			rx_tog <= next_rx_tog;
		end
	end

	// falling edge: load a byte at a boundary, else shift out; works for mode 0 and 3
	always_comb begin
		next_tx_sr = tx_sr;
		next_tx_ack = tx_ack;
		if (!hold_now) begin
			if (bit_cnt == sfpfe_pkg::SFPFE_CNT_RESET) begin
				next_tx_sr = tx_hold;
				// a fall while deselected must not acknowledge a byte that never left
				next_tx_ack = frame_rst_n ? tx_req : tx_ack;
			end else begin
				next_tx_sr = tx_sr << step;
			end
		end
	end

	always_ff @(negedge sck_i or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			tx_sr <= sfpfe_pkg::SFPFE_BYTE_RESET;
		end else begin
			tx_sr <= next_tx_sr;
		end
	end

	// ack toggle kept outside the frame reset so the handshake stays balanced
	always_ff @(negedge sck_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_ack <= 1'b0;
		end else begin
			tx_ack <= next_tx_ack;
		end
	end

	// pad drive: data from flops, enables gated by select, pause and reset
	logic drive_ok;
	always_comb begin
		drive_ok = out_dir && frame_rst_n && !hold_now;
		data_lane_0_o = 1'b0;
		data_lane_1_o = tx_sr[7];
		data_lane_2_o = 1'b0;
		data_lane_3_o = 1'b0;
		data_lane_0_oe_o = 1'b0;
		data_lane_1_oe_o = drive_ok;
		data_lane_2_oe_o = 1'b0;
		data_lane_3_oe_o = 1'b0;
		case (sfpfe_pkg::sfpfe_lanes_type'(lane_mode))
			sfpfe_pkg::SFPFE_LANES_TWO: begin
				{data_lane_1_o, data_lane_0_o} = tx_sr[7:6];
				data_lane_0_oe_o = drive_ok;
			end
			sfpfe_pkg::SFPFE_LANES_FOUR: begin
				{data_lane_3_o, data_lane_2_o, data_lane_1_o, data_lane_0_o} = tx_sr[7:4];
				data_lane_0_oe_o = drive_ok;
				data_lane_2_oe_o = drive_ok;
				data_lane_3_oe_o = drive_ok;
			end
			default: begin
			end
		endcase
	end

	// core domain: two-flop synchronisers for the pin and link-clock control levels; rx_byte is read unsynchronised
	logic [1:0] cs_sync;
	logic [1:0] rst_sync;
	logic [1:0] hold_sync;
	logic [1:0] wp_sync;
	logic [1:0] rx_tog_sync;
	logic [1:0] ack_sync;
	logic rx_tog_seen;
	logic next_armed;
	logic next_rx_tog_seen;
	logic [7:0] next_rx_data;
	logic next_rx_valid;
	logic [7:0] next_tx_hold;
	logic next_tx_req;

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cs_sync <= 2'h3;
			rst_sync <= 2'h0;
			hold_sync <= 2'h0;
			wp_sync <= 2'h3;
			rx_tog_sync <= 2'h0;
			ack_sync <= 2'h0;
		end else begin
			cs_sync <= {cs_sync[0], cs_n_i};
			rst_sync <= {rst_sync[0], reset_now};
			hold_sync <= {hold_sync[0], hold_now};
			wp_sync <= {wp_sync[0], data_lane_2_i};
			rx_tog_sync <= {rx_tog_sync[0], rx_tog};
			ack_sync <= {ack_sync[0], tx_ack};
		end
	end

	// arming: dropped by reset, regained only once chip select is seen high
	always_comb begin
		next_armed = armed;
		// only the synchronised reset level reaches this flop; the link side is held by
		// the raw level meanwhile, but pulses under one core cycle may slip past arming
		if (rst_sync[1]) begin
			next_armed = 1'b0;
		end else if (cs_sync[1]) begin
			next_armed = 1'b1;
		end
		next_quad_lane_enable = quad_lane_enable_i;
		next_pin_function_select = pin_function_select_i;
		next_lane_mode = lane_mode_i;
		next_out_dir = out_dir_i;
		// byte handed over when the received toggle has crossed
		next_rx_tog_seen = rx_tog_sync[1];
		next_rx_valid = rx_tog_sync[1] != rx_tog_seen;
		next_rx_data = next_rx_valid ? rx_byte : rx_data_o;
		// one byte in flight; the link reloads the last byte if none is new
		next_tx_hold = tx_hold;
		next_tx_req = tx_req;
		if (tx_valid_i && tx_ready_o) begin
			next_tx_hold = tx_data_i;
			next_tx_req = !tx_req;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			armed <= 1'b0;
			quad_lane_enable <= sfpfe_pkg::SFPFE_QE_RESET;
			pin_function_select <= sfpfe_pkg::SFPFE_PFS_RESET;
			lane_mode <= 2'h0;
			out_dir <= 1'b0;
			rx_tog_seen <= 1'b0;
			rx_valid_o <= 1'b0;
			rx_data_o <= sfpfe_pkg::SFPFE_BYTE_RESET;
			tx_hold <= sfpfe_pkg::SFPFE_BYTE_RESET;
			tx_req <= 1'b0;
		end else begin
			armed <= next_armed;
			quad_lane_enable <= next_quad_lane_enable;
			pin_function_select <= next_pin_function_select;
			lane_mode <= next_lane_mode;
			out_dir <= next_out_dir;
			rx_tog_seen <= next_rx_tog_seen;
			rx_valid_o <= next_rx_valid;
			rx_data_o <= next_rx_data;
			tx_hold <= next_tx_hold;
			tx_req <= next_tx_req;
		end
	end

	// status towards the core, all from synchronised levels
	assign tx_ready_o = ack_sync[1] == tx_req;
	assign selected_o = !cs_sync[1] && armed;
	assign hold_active_o = hold_sync[1];
	assign hw_reset_active_o = rst_sync[1];
	// write protect only means something outside four-lane use
	assign write_protect_n_o = quad_lane_enable || wp_sync[1];

endmodule // sfpfe_front_end

// ### verif/sfpfe_assertions.sv
// port checker of the pin-mode front end
`timescale 1ns/10ps

module sfpfe_assertions (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic cs_n_i,
	input wire logic data_lane_3_i,
	input wire logic data_lane_0_oe_o,
	input wire logic data_lane_1_oe_o,
	input wire logic data_lane_2_oe_o,
	input wire logic quad_lane_enable_i,
	input wire logic pin_function_select_i,
	input wire logic rx_valid_o,
	input wire logic hold_active_o,
	input wire logic hw_reset_active_o,
	input wire logic write_protect_n_o
);
	logic pin_low;
	logic any_oe;
	logic cfg_same;
	// shared pin low while it keeps its control role
	assign pin_low = !data_lane_3_i && !quad_lane_enable_i;
	assign any_oe = data_lane_0_oe_o || data_lane_1_oe_o || data_lane_2_oe_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// config is registered inside, so only judge it once it has settled
	always_ff @(posedge clk_i) begin
		cfg_same <= $stable(quad_lane_enable_i) && $stable(pin_function_select_i);
	end
	sequence s_qe_on;
		quad_lane_enable_i [*5];
	endsequence
	sequence s_pause_on;
		(pin_low && !pin_function_select_i && !cs_n_i) [*4];
	endsequence
	sequence s_reset_on;
		(pin_low && pin_function_select_i) [*4];
	endsequence
	chk_cs_high_float: assert property (cs_n_i |-> !any_oe)
		else $error("lane driven while deselected");
	chk_pause_float: assert property (pin_low && !pin_function_select_i && !cs_n_i && cfg_same
		|-> !data_lane_1_oe_o)
		else $error("output driven while paused");
	chk_reset_float: assert property (pin_low && pin_function_select_i && cfg_same |-> !any_oe)
		else $error("lane driven in reset");
	chk_pause_seen: assert property (s_pause_on |-> hold_active_o && !hw_reset_active_o)
		else $error("pause not flagged");
	chk_reset_seen: assert property (s_reset_on |-> hw_reset_active_o && !hold_active_o)
		else $error("reset not flagged");
	chk_qe_no_pause: assert property (s_qe_on |-> !hold_active_o && !hw_reset_active_o)
		else $error("control role kept with four lanes");
	chk_qe_wp_free: assert property (s_qe_on |-> write_protect_n_o)
		else $error("write protect active with four lanes");
	chk_rx_pulse_once: assert property (rx_valid_o |=> !rx_valid_o)
		else $error("receive strobe too long");
endmodule // sfpfe_assertions

bind sfpfe_front_end sfpfe_assertions i_chk (.clk_i(clk_i), .nrst_i(nrst_i), .cs_n_i(cs_n_i),
	.data_lane_3_i(data_lane_3_i), .data_lane_0_oe_o(data_lane_0_oe_o),
	.data_lane_1_oe_o(data_lane_1_oe_o), .data_lane_2_oe_o(data_lane_2_oe_o),
	.quad_lane_enable_i(quad_lane_enable_i), .pin_function_select_i(pin_function_select_i),
	.rx_valid_o(rx_valid_o), .hold_active_o(hold_active_o),
	.hw_reset_active_o(hw_reset_active_o), .write_protect_n_o(write_protect_n_o));

// ### verif/sfpfe_master_model.sv
// serial bus master model for the link side
`timescale 1ns/10ps

module sfpfe_master_model (
	output logic sck_o,
	output logic cs_n_o,
	output logic [3:0] drv_o,
	input wire logic [3:0] lane_i
);
	initial begin
		sck_o = 1'h0;
		cs_n_o = 1'h1;
		drv_o = 4'hF;
	end
	// two bytes per frame on w lanes: in mode 0 the first loading fall only follows the first
	// byte, so the device's byte is read in the second; at step k of the second byte
	// the shared pin is pulled low while the clock keeps running
	task automatic frame(input bit cpol, input int w, input logic [7:0] mo, input int k,
		output logic [7:0] mi);
		mi = 8'h00;
		sck_o = cpol;
		#24 cs_n_o = 1'h0;
		for (int b = 0; b < 2; b++) begin
			for (int i = 8 - w; i >= 0; i -= w) begin
				if (b == 1 && i == k) begin
					drv_o[3] = 1'h0;
					// edges and data seen while paused must be ignored
					repeat (2) begin
						#12 sck_o = 1'h0;
						drv_o[0] = ~drv_o[0];
						#12 sck_o = 1'h1;
					end
					#12 drv_o[3] = 1'h1;
					#6;
				end
				// lanes 0 to 2 keep changing when not carrying data so a stale value never passes; lane 3 stays high
				for (int j = 0; j < 4; j++) begin
					drv_o[j] = j < w ? mo[i + j] : (j == 3 ? 1'h1 : ~drv_o[j]);
				end
				sck_o = 1'h0;
				#6;
				if (b == 1) begin
					for (int j = 0; j < w; j++) begin
						mi[i + j] = w == 1 ? lane_i[1] : lane_i[j];
					end
				end
				sck_o = 1'h1;
				#6;
			end
		end
		sck_o = cpol;
		#12 cs_n_o = 1'h1;
		drv_o = 4'hF;
		#36;
	endtask
endmodule // sfpfe_master_model

// ### verif/tb_top.sv
// self-checking bench of the pin-mode front end
`timescale 1ns/10ps

module tb_top;
	logic clk_i, nrst_i, sck, cs_n, qe, pfs, dir, txv, rdy, rxv, sel;
	logic [1:0] lm;
	logic [3:0] oe, dout, mdrv, lane;
	logic [7:0] txd, rxd;
	logic [7:0] expq[$];
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	// a lane carries the device value only while it drives
	assign lane = (oe & dout) | (~oe & mdrv);
	sfpfe_front_end i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .sck_i(sck), .cs_n_i(cs_n),
		.reset_pin_n_i(1'h1), .data_lane_0_i(lane[0]), .data_lane_0_o(dout[0]),
		.data_lane_0_oe_o(oe[0]), .data_lane_1_i(lane[1]), .data_lane_1_o(dout[1]),
		.data_lane_1_oe_o(oe[1]), .data_lane_2_i(lane[2]), .data_lane_2_o(dout[2]),
		.data_lane_2_oe_o(oe[2]), .data_lane_3_i(lane[3]), .data_lane_3_o(dout[3]),
		.data_lane_3_oe_o(oe[3]), .quad_lane_enable_i(qe), .pin_function_select_i(pfs),
		.lane_mode_i(lm), .out_dir_i(dir), .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(rdy),
		.rx_data_o(rxd), .rx_valid_o(rxv), .selected_o(sel), .hold_active_o(),
		.hw_reset_active_o(), .write_protect_n_o());
	sfpfe_master_model i_mst (.sck_o(sck), .cs_n_o(cs_n), .drv_o(mdrv), .lane_i(lane));
	initial begin
		clk_i = 1'h0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (miscompares == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// received bytes against the queue; read frames may echo, so only writes expect silence
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (rxv === 1'h1 && (expq.size() > 0 || !dir)) begin
			cmp(rxd, expq.size() > 0 ? expq.pop_front() : 8'hXX);
		end
		if (cycles == 20000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	// configure, offer a byte on reads, queue the bytes the device must receive, run one frame, check the byte it sent
	task automatic run(input bit cpol, input int l, input bit d, input bit p, input int k);
		logic [7:0] mo, mi, ty;
		mo = 8'($urandom);
		ty = 8'($urandom);
		@(posedge clk_i);
		lm <= 2'(l);
		qe <= (l == 2);
		dir <= d;
		pfs <= p;
		txd <= ty;
		txv <= d;
		// the byte is only taken at an edge where ready was high
		do @(posedge clk_i); while (d && rdy !== 1'h1);
		txv <= 1'h0;
		repeat (10) @(posedge clk_i);
		// a hardware reset in the second byte leaves only the first one received
		if (!d || l == 0) repeat ((p && k < 8) ? 1 : 2) expq.push_back(mo);
		fork
			i_mst.frame(cpol, 1 << l, mo, k, mi);
			begin
				repeat (8) @(posedge clk_i);
				cmp(8'(sel), 8'h01);
			end
		join
		if (d && !(p && k < 8)) cmp(mi, ty);
		repeat (12) @(posedge clk_i);
		cmp(8'(sel), 8'h00);
	endtask
	initial begin
		void'($urandom(32'h56C3));
		nrst_i = 1'h0;
		qe = 1'h0;
		pfs = 1'h0;
		dir = 1'h0;
		txv = 1'h0;
		lm = 2'h0;
		txd = 8'h00;
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		for (int t = 0; t < 12; t++) begin
			run(t % 2 == 1, (t / 2) % 3, t >= 6, 1'h0, 99);
		end
		run(1'h0, 0, 1'h1, 1'h0, 4);
		run(1'h1, 0, 1'h1, 1'h0, 4);
		// reset is pulled only inside a plain byte frame, in the first of the two runs
		run(1'h0, 0, 1'h1, 1'h1, 4);
		run(1'h1, 0, 1'h1, 1'h1, 99);
		cmp(8'(expq.size()), 8'h00);
		tally_and_finish();
	end
endmodule // tb_top
